// >>> core/slts_consts.vh
// Constants for the serial link test, identifier, frame character and status block.
`ifndef SLTS_CONSTS_VH
`define SLTS_CONSTS_VH
// Register offsets.
`define SLTS_ADR_LINK_EN 10'h200
`define SLTS_ADR_TEST 10'h205
`define SLTS_ADR_DEVID 10'h206
`define SLTS_ADR_EOF 10'h207
`define SLTS_ADR_STATE 10'h208
// Reset values.
`define SLTS_RST_LINK_EN 1'h1
`define SLTS_RST_TEST 4'h0
`define SLTS_RST_DEVID 7'h00
`define SLTS_RST_EOF 2'h0
// Field positions in the state register.
`define SLTS_BIT_LINK_UP 6
`define SLTS_BIT_SYNC 5
`define SLTS_BIT_REALIGN 4
`define SLTS_BIT_PHASE 3
`define SLTS_BIT_PLL 2
// Test pattern codes.
`define SLTS_TP_NORMAL 4'h0
`define SLTS_TP_PRBS7 4'h1
`define SLTS_TP_PRBS15 4'h2
`define SLTS_TP_PRBS23 4'h3
`define SLTS_TP_RAMP 4'h4
`define SLTS_TP_TRANSPORT 4'h5
`define SLTS_TP_D215 4'h6
`define SLTS_TP_K285 4'h7
`define SLTS_TP_ILA 4'h8
`define SLTS_TP_RPAT 4'h9
`define SLTS_TP_LOW 4'ha
`define SLTS_TP_HIGH 4'hb
// End-of-frame selector codes.
`define SLTS_EOF_K287 2'h0
`define SLTS_EOF_K281 2'h1
`define SLTS_EOF_K285 2'h2
// Octet values of the characters.
`define SLTS_D215 8'hb5
`define SLTS_K285 8'hbc
`define SLTS_K287 8'hfc
`define SLTS_K281 8'h3c
`define SLTS_K280 8'h1c
`define SLTS_K283 8'h7c
`define SLTS_K284 8'h9c
// Index of the last multiframe in the alignment sequence, which has four multiframes.
`define SLTS_ILA_MF 2'h3
// Multiframe of the alignment sequence that carries the identifier, and octet positions within it.
`define SLTS_ILA_MF_CFG 2'h1
`define SLTS_POS_QCHAR 16'h0001
`define SLTS_POS_DEVID 16'h0002
// LFSR seed.
`define SLTS_SEED 23'h7fffff
`endif

// >>> core/slts_top.v
// Serial link test pattern, alignment identifier, frame character and status block.
// Operation
// - Test select is bits 3-0, resets zero; zero sends normal data.
// - Values 1, 2, 3 send PRBS of order 7, 15, 23.
// - Value 4 sends a ramp, value 5 the transport layer pattern.
// - Value 6 repeats D21.5, value 7 repeats K28.5.
// - Value 8 repeats alignment sequence, value 9 modified random pattern.
// - Value 10 holds outputs low, 11 high; 12 to 15 reserved.
// - Device identifier is sent in the second alignment multiframe.
// - First link sends the identifier, second link sends identifier plus one.
// - Identifier bit zero is ignored and reads zero.
// - Two-bit selector picks K28.7, K28.1 or K28.5 end character.
// - End character replaces frame-final data only when substitution conditions hold.
// - State bit 6 reads one while the link is up.
// - State bit 5 reads live sync request, zero while asserted.
// - State bit 4 sets on phase shift by SYSREF; write one clears.
// - State bit 3 sets on first SYSREF after enable; write one clears.
// - State bit 2 reads one while serializer PLL is locked.
// - Link enable clear holds transmitter reset, serializers down, multiframe counter held.
`timescale 1ns/100ps
`default_nettype none
`include "slts_consts.vh"
module slts_top #(
	parameter OCTETS_PER_FRAME = 2,
	parameter FRAMES_PER_MF = 32
) (
	input wire clk,
	input wire rst_n,
	input wire [9:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [7:0] sample_a,
	input wire [7:0] sample_b,
	input wire sync_req_n,
	input wire sysref,
	input wire pll_locked,
	output reg [7:0] lane_a_ff,
	output reg lane_a_k_ff,
	output reg [7:0] lane_b_ff,
	output reg lane_b_k_ff,
	output reg ser_power_down_ff,
	output reg ser_force_low_ff,
	output reg ser_force_high_ff
);
	localparam ST_CGS = 2'h0;
	localparam ST_ILA = 2'h1;
	localparam ST_DATA = 2'h2;

	reg link_en_ff;
	reg [3:0] test_sel_ff;
	reg [6:0] devid_ff;
	reg [1:0] eof_sel_ff;
	reg realign_ff;
	reg phase_ff;
	reg link_up_ff;
	reg [1:0] state_ff;
	reg [7:0] oct_cnt_ff;
	reg [7:0] frm_cnt_ff;
	reg [1:0] mf_cnt_ff;
	reg [15:0] pos_cnt_ff;
	reg phase_seen_ff;
	reg [22:0] lfsr_ff;
	reg [7:0] ramp_ff;
	reg [7:0] last_a_ff;
	reg [7:0] last_b_ff;
	reg [3:0] rpat_ff;
	reg [7:0] nxt_a;
	reg nxt_a_k;
	reg [7:0] nxt_b;
	reg nxt_b_k;
	reg [7:0] eof_char;
	reg [22:0] nxt_lfsr;
	reg [7:0] prbs_oct;
	reg [7:0] rd_mux;
	wire [7:0] devid_full;
	wire [7:0] devid_b;
	wire frame_end;
	wire mf_end;
	wire wr_state;
	wire [7:0] cfg_state;
	wire q_slot;
	wire did_slot;

	// Identifier with bit zero forced low; link B carries one more.
	assign devid_full = {devid_ff, 1'b0};
	assign devid_b = devid_full + 8'h01;
	assign frame_end = (oct_cnt_ff == OCTETS_PER_FRAME - 1);
	assign mf_end = frame_end && (frm_cnt_ff == FRAMES_PER_MF - 1);
	assign wr_state = reg_wr && (reg_addr == `SLTS_ADR_STATE);
	assign q_slot = (state_ff == ST_ILA) && (mf_cnt_ff == `SLTS_ILA_MF_CFG) && (pos_cnt_ff == `SLTS_POS_QCHAR);
	assign did_slot = (state_ff == ST_ILA) && (mf_cnt_ff == `SLTS_ILA_MF_CFG) && (pos_cnt_ff == `SLTS_POS_DEVID);

	// Configuration registers; settings are expected to change only while disabled.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_en_ff <= `SLTS_RST_LINK_EN;
			test_sel_ff <= `SLTS_RST_TEST;
			devid_ff <= `SLTS_RST_DEVID;
			eof_sel_ff <= `SLTS_RST_EOF;
		end else if (reg_wr) begin
			case (reg_addr)
			`SLTS_ADR_LINK_EN: begin
				link_en_ff <= reg_wdata[0];
			end
			`SLTS_ADR_TEST: begin
				test_sel_ff <= reg_wdata[3:0];
			end
			`SLTS_ADR_DEVID: begin
				devid_ff <= reg_wdata[7:1];
			end
			`SLTS_ADR_EOF: begin
				eof_sel_ff <= reg_wdata[1:0];
			end
			default: begin
				link_en_ff <= link_en_ff;
			end
			endcase
		end
	end

	// Alignment flags: SYSREF sets them, a write of one clears, set beats clear.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			realign_ff <= 1'b0;
			phase_ff <= 1'b0;
			phase_seen_ff <= 1'b0;
		end else begin
			if (!link_en_ff) begin
				phase_seen_ff <= 1'b0;
			end else if (sysref) begin
				phase_seen_ff <= 1'b1;
			end
			if (link_en_ff && sysref && (oct_cnt_ff != 8'h00 || frm_cnt_ff != 8'h00)) begin
				realign_ff <= 1'b1;
			end else if (wr_state && reg_wdata[`SLTS_BIT_REALIGN]) begin
				realign_ff <= 1'b0;
			end
			if (link_en_ff && sysref && !phase_seen_ff) begin
				phase_ff <= 1'b1;
			end else if (wr_state && reg_wdata[`SLTS_BIT_PHASE]) begin
				phase_ff <= 1'b0;
			end
		end
	end

	// Frame and multiframe counters; held at zero while disabled, SYSREF restarts them.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oct_cnt_ff <= 8'h00;
			frm_cnt_ff <= 8'h00;
			pos_cnt_ff <= 16'h0000;
		end else if (!link_en_ff || sysref) begin
			oct_cnt_ff <= 8'h00;
			frm_cnt_ff <= 8'h00;
			pos_cnt_ff <= 16'h0000;
		end else if (frame_end) begin
			oct_cnt_ff <= 8'h00;
			frm_cnt_ff <= mf_end ? 8'h00 : frm_cnt_ff + 8'h01;
			pos_cnt_ff <= mf_end ? 16'h0000 : pos_cnt_ff + 16'h0001;
		end else begin
			oct_cnt_ff <= oct_cnt_ff + 8'h01;
			pos_cnt_ff <= pos_cnt_ff + 16'h0001;
		end
	end

	// Link sequencer: sync groups, alignment sequence, then data.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_CGS;
			mf_cnt_ff <= 2'h0;
			link_up_ff <= 1'b0;
		end else if (!link_en_ff || !sync_req_n) begin
			state_ff <= ST_CGS;
			mf_cnt_ff <= 2'h0;
			link_up_ff <= 1'b0;
		end else begin
			case (state_ff)
			ST_CGS: begin
				if (mf_end) begin
					state_ff <= ST_ILA;
				end
			end
			ST_ILA: begin
				if (mf_end) begin
					mf_cnt_ff <= mf_cnt_ff + 2'h1;
					if (mf_cnt_ff == `SLTS_ILA_MF && test_sel_ff != `SLTS_TP_ILA) begin
						state_ff <= ST_DATA;
					end
				end
			end
			ST_DATA: begin
				link_up_ff <= pll_locked;
			end
			default: begin
				state_ff <= ST_CGS;
			end
			endcase
		end
	end

	// Advance the LFSR eight bits for the selected order.
	always @* begin : prbs_step
		integer i;
		reg fb;
		nxt_lfsr = lfsr_ff;
		prbs_oct = 8'h00;
		fb = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			case (test_sel_ff)
			`SLTS_TP_PRBS7: fb = nxt_lfsr[6] ^ nxt_lfsr[5];
			`SLTS_TP_PRBS15: fb = nxt_lfsr[14] ^ nxt_lfsr[13];
			default: fb = nxt_lfsr[22] ^ nxt_lfsr[17];
			endcase
			prbs_oct = {prbs_oct[6:0], fb};
			nxt_lfsr = {nxt_lfsr[21:0], fb};
		end
	end

	// Pattern sources that run free while enabled.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_ff <= `SLTS_SEED;
			ramp_ff <= 8'h00;
			rpat_ff <= 4'h0;
		end else if (!link_en_ff) begin
			lfsr_ff <= `SLTS_SEED;
			ramp_ff <= 8'h00;
			rpat_ff <= 4'h0;
		end else begin
			lfsr_ff <= nxt_lfsr;
			ramp_ff <= ramp_ff + 8'h01;
			rpat_ff <= rpat_ff + 4'h1;
		end
	end

	// End-of-frame character choice.
	always @* begin
		case (eof_sel_ff)
		`SLTS_EOF_K281: eof_char = `SLTS_K281;
		`SLTS_EOF_K285: eof_char = `SLTS_K285;
		default: eof_char = `SLTS_K287;
		endcase
	end

	// Octet selection for both lanes.
	always @* begin
		nxt_a = sample_a;
		nxt_a_k = 1'b0;
		nxt_b = sample_b;
		nxt_b_k = 1'b0;
		if (state_ff == ST_CGS && test_sel_ff == `SLTS_TP_NORMAL) begin
			nxt_a = `SLTS_K285;
			nxt_a_k = 1'b1;
		end else begin
			case (test_sel_ff)
			`SLTS_TP_NORMAL: begin
				if (state_ff == ST_DATA && frame_end) begin
					if (sample_a == last_a_ff) begin
						nxt_a = eof_char;
						nxt_a_k = 1'b1;
					end
					if (sample_b == last_b_ff) begin
						nxt_b = eof_char;
						nxt_b_k = 1'b1;
					end
				end
			end
			`SLTS_TP_PRBS7, `SLTS_TP_PRBS15, `SLTS_TP_PRBS23: begin
				nxt_a = prbs_oct;
				nxt_b = prbs_oct;
			end
			`SLTS_TP_RAMP: begin
				nxt_a = ramp_ff;
				nxt_b = ramp_ff;
			end
			`SLTS_TP_TRANSPORT: begin
				nxt_a = {oct_cnt_ff[3:0], frm_cnt_ff[3:0]};
				nxt_b = {oct_cnt_ff[3:0], ~frm_cnt_ff[3:0]};
			end
			`SLTS_TP_D215: begin
				nxt_a = `SLTS_D215;
				nxt_b = `SLTS_D215;
			end
			`SLTS_TP_K285: begin
				nxt_a = `SLTS_K285;
				nxt_a_k = 1'b1;
				nxt_b = `SLTS_K285;
				nxt_b_k = 1'b1;
			end
			`SLTS_TP_ILA: begin
				nxt_a = ramp_ff;
				nxt_b = ramp_ff;
			end
			`SLTS_TP_RPAT: begin
				nxt_a = {rpat_ff, ~rpat_ff} ^ `SLTS_D215;
				nxt_b = nxt_a;
			end
			default: begin
				nxt_a = 8'h00;
				nxt_b = 8'h00;
			end
			endcase
		end
		// Alignment multiframes override data, repeating in test value 8.
		if (state_ff == ST_ILA) begin
			nxt_a_k = 1'b0;
			nxt_b_k = 1'b0;
			if (oct_cnt_ff == 8'h00 && frm_cnt_ff == 8'h00) begin
				nxt_a = `SLTS_K280;
				nxt_a_k = 1'b1;
			end else if (mf_end) begin
				nxt_a = `SLTS_K283;
				nxt_a_k = 1'b1;
			end else if (q_slot) begin
				nxt_a = `SLTS_K284;
				nxt_a_k = 1'b1;
			end else if (did_slot) begin
				nxt_a = devid_full;
			end else begin
				nxt_a = ramp_ff;
			end
			nxt_b = nxt_a;
			nxt_b_k = nxt_a_k;
			if (did_slot && !nxt_a_k) begin
				nxt_b = devid_b;
			end
		end
	end

	// Lane output registers; outputs held quiet while disabled.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_a_ff <= 8'h00;
			lane_a_k_ff <= 1'b0;
			lane_b_ff <= 8'h00;
			lane_b_k_ff <= 1'b0;
			last_a_ff <= 8'h00;
			last_b_ff <= 8'h00;
			ser_power_down_ff <= 1'b1;
			ser_force_low_ff <= 1'b0;
			ser_force_high_ff <= 1'b0;
		end else if (!link_en_ff) begin
			lane_a_ff <= 8'h00;
			lane_a_k_ff <= 1'b0;
			lane_b_ff <= 8'h00;
			lane_b_k_ff <= 1'b0;
			last_a_ff <= 8'h00;
			last_b_ff <= 8'h00;
			ser_power_down_ff <= 1'b1;
			ser_force_low_ff <= 1'b0;
			ser_force_high_ff <= 1'b0;
		end else begin
			lane_a_ff <= nxt_a;
			lane_a_k_ff <= nxt_a_k;
			lane_b_ff <= nxt_b;
			lane_b_k_ff <= nxt_b_k;
			if (frame_end) begin
				last_a_ff <= sample_a;
				last_b_ff <= sample_b;
			end
			ser_power_down_ff <= 1'b0;
			ser_force_low_ff <= (test_sel_ff == `SLTS_TP_LOW);
			ser_force_high_ff <= (test_sel_ff == `SLTS_TP_HIGH);
		end
	end

	// State register image.
	assign cfg_state = {1'b0, link_up_ff, sync_req_n, realign_ff, phase_ff, pll_locked, 2'h0};

	// Read multiplexer; unmapped offsets read zero.
	always @* begin
		case (reg_addr)
		`SLTS_ADR_LINK_EN: rd_mux = {7'h00, link_en_ff};
		`SLTS_ADR_TEST: rd_mux = {4'h0, test_sel_ff};
		`SLTS_ADR_DEVID: rd_mux = devid_full;
		`SLTS_ADR_EOF: rd_mux = {6'h00, eof_sel_ff};
		`SLTS_ADR_STATE: rd_mux = cfg_state;
		default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands in the cycle after the strobe only.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end
endmodule // slts_top
`default_nettype wire

// >>> testbench/slts_monitor.sv
// Port assertions for the serial link test and status block.
`timescale 1ns/100ps
`default_nettype none
module slts_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sync_req_n,
	input wire logic sysref,
	input wire logic pll_locked,
	input wire logic [7:0] lane_a_ff,
	input wire logic lane_a_k_ff,
	input wire logic [7:0] lane_b_ff,
	input wire logic ser_power_down_ff,
	input wire logic ser_force_low_ff,
	input wire logic ser_force_high_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic st;
	logic seen;
	// Remembers a SYSREF since the serializers were last powered up.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen <= 1'b0;
		end else if (sysref) begin
			seen <= 1'b1;
		end else if (ser_power_down_ff) begin
			seen <= 1'b0;
		end
	end
	// A read of the state register is under way.
	assign st = reg_rd && reg_addr == 10'h208;
	property p_sync; st |=> reg_rdata[5] == $past(sync_req_n); endproperty
	a_sync: assert property (p_sync) else $error("sync bit wrong");
	property p_pll; st |=> reg_rdata[2] == $past(pll_locked); endproperty
	a_pll: assert property (p_pll) else $error("lock bit wrong");
	property p_rsvd; st |=> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved state bits set");
	property p_even; reg_rd && reg_addr == 10'h206 |=> !reg_rdata[0]; endproperty
	a_even: assert property (p_even) else $error("identifier bit zero set");
	property p_test; reg_rd && reg_addr == 10'h205 |=> reg_rdata[7:4] == 4'h0; endproperty
	a_test: assert property (p_test) else $error("test select too wide");
	property p_force; ser_force_low_ff |-> !ser_force_high_ff && lane_a_ff == 8'h00 && lane_b_ff == 8'h00; endproperty
	a_force: assert property (p_force) else $error("forced low not quiet");
	property p_pd; ser_power_down_ff |-> lane_a_ff == 8'h00 && !lane_a_k_ff; endproperty
	a_pd: assert property (p_pd) else $error("lanes active while disabled");
	sequence s_run; (!ser_power_down_ff && !reg_wr)[*3] ##0 sysref; endsequence
	property p_phase; s_run ##0 !seen ##1 !reg_wr ##1 st |=> reg_rdata[3]; endproperty
	a_phase: assert property (p_phase) else $error("phase flag not set");
	property p_realign; s_run ##1 !reg_wr[*2] ##1 sysref ##1 !reg_wr ##1 st |=> reg_rdata[4]; endproperty
	a_realign: assert property (p_realign) else $error("realign flag not set");
	c_read: cover property (st);
	c_high: cover property (ser_force_high_ff);
	c_ila: cover property (lane_a_k_ff && lane_a_ff == 8'h9c);
endmodule // slts_monitor
bind slts_top slts_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_req_n(sync_req_n), .sysref(sysref), .pll_locked(pll_locked),
	.lane_a_ff(lane_a_ff), .lane_a_k_ff(lane_a_k_ff), .lane_b_ff(lane_b_ff), .ser_power_down_ff(ser_power_down_ff),
	.ser_force_low_ff(ser_force_low_ff), .ser_force_high_ff(ser_force_high_ff));
`default_nettype wire

// >>> testbench/slts_receiver_model.sv
// Far-side receiver that holds its sync request until a run of commas arrives.
`timescale 1ns/100ps
`default_nettype none
module slts_receiver_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic [7:0] lane_a,
	input wire logic lane_a_k,
	output logic sync_req_n
);
	logic [2:0] cnt_ff;
	logic sync_ff;
	assign sync_req_n = sync_ff;
	// Releases the request after four K28.5 octets; it never realigns on data commas.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
			sync_ff <= 1'b0;
		end else if (hold) begin
			cnt_ff <= 3'h0;
			sync_ff <= 1'b0;
		end else if (cnt_ff == 3'h4) begin
			sync_ff <= 1'b1;
		end else if (lane_a_k && lane_a == 8'hbc) begin
			cnt_ff <= cnt_ff + 3'h1;
		end else begin
			cnt_ff <= 3'h0;
		end
	end
endmodule // slts_receiver_model
`default_nettype wire

// >>> testbench/slts_top_bench.sv
// Self-checking bench for the serial link test and status block.
`timescale 1ns/100ps
`default_nettype none
`include "slts_consts.vh"
module slts_top_bench;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sysref = 0, pll_locked = 1, hold = 1;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00, sample_a = 8'h33, sample_b = 8'h44;
	logic [7:0] reg_rdata, lane_a, lane_b;
	logic lane_a_k, lane_b_k, pd, flo, fhi, sync_req_n;
	logic [7:0] tcode [5] = '{8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c};
	logic [7:0] tlane [5] = '{8'hb5, 8'hbc, 8'h00, 8'h00, 8'h00};
	logic [2:0] tflag [5] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b000};
	logic [7:0] v;
	int n_fail = 0, num_checks = 0, i;
	slts_top #(.OCTETS_PER_FRAME(2), .FRAMES_PER_MF(4)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_a(sample_a),
		.sample_b(sample_b), .sync_req_n(sync_req_n), .sysref(sysref), .pll_locked(pll_locked),
		.lane_a_ff(lane_a), .lane_a_k_ff(lane_a_k), .lane_b_ff(lane_b), .lane_b_k_ff(lane_b_k),
		.ser_power_down_ff(pd), .ser_force_low_ff(flo), .ser_force_high_ff(fhi));
	slts_receiver_model rx (.clk(clk), .rst_n(rst_n), .hold(hold), .lane_a(lane_a), .lane_a_k(lane_a_k),
		.sync_req_n(sync_req_n));
	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic pulse;
		@(posedge clk);
		sysref <= 1'b1;
		@(posedge clk);
		sysref <= 1'b0;
	endtask
	task automatic wait_lane(input logic [7:0] v);
		int t;
		t = 0;
		while (!(lane_a_k === 1'b1 && lane_a === v) && t < 300) begin
			@(posedge clk);
			#1 t++;
		end
		chk(lane_a, v);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog: the tests need well under a thousand cycles.
	initial begin
		#20000;
		n_fail++;
		final_report;
	end
	// Main sequence of tests.
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`SLTS_ADR_TEST, 8'hff, 8'h00);
		rd(`SLTS_ADR_EOF, 8'hff, 8'h00);
		rd(10'h3ff, 8'hff, 8'h00);
		wr(`SLTS_ADR_LINK_EN, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk({7'h0, pd}, 8'h01);
		chk(lane_a, 8'h00);
		$display("reset and disable test done");
		for (i = 0; i < 5; i++) begin
			wr(`SLTS_ADR_TEST, tcode[i]);
			wr(`SLTS_ADR_LINK_EN, 8'h01);
			repeat (6) @(posedge clk);
			#1 chk(lane_a, tlane[i]);
			chk({5'h0, lane_a_k, flo, fhi}, {5'h0, tflag[i]});
			chk({7'h0, lane_b_k}, {7'h0, tflag[i][2]});
			wr(`SLTS_ADR_LINK_EN, 8'h00);
		end
		wr(`SLTS_ADR_TEST, 8'h04);
		wr(`SLTS_ADR_LINK_EN, 8'h01);
		repeat (6) @(posedge clk);
		#1 v = lane_a;
		@(posedge clk);
		#1 chk(lane_a, v + 8'h01);
		chk(lane_b, v + 8'h01);
		wr(`SLTS_ADR_LINK_EN, 8'h00);
		wr(`SLTS_ADR_TEST, 8'h01);
		wr(`SLTS_ADR_LINK_EN, 8'h01);
		repeat (6) @(posedge clk);
		#1 v = lane_a;
		repeat (127) @(posedge clk);
		#1 chk(lane_a, v);
		wr(`SLTS_ADR_LINK_EN, 8'h00);
		$display("test pattern test done");
		wr(`SLTS_ADR_TEST, 8'h00);
		wr(`SLTS_ADR_DEVID, 8'h57);
		rd(`SLTS_ADR_DEVID, 8'hff, 8'h56);
		wr(`SLTS_ADR_EOF, 8'h01);
		rd(`SLTS_ADR_EOF, 8'hff, 8'h01);
		@(posedge clk);
		hold <= 1'b0;
		wr(`SLTS_ADR_LINK_EN, 8'h01);
		repeat (4) @(posedge clk);
		pulse();
		rd(`SLTS_ADR_STATE, 8'h08, 8'h08);
		wait_lane(`SLTS_K284);
		@(posedge clk);
		#1 chk(lane_a, 8'h56);
		chk(lane_b, 8'h57);
		wait_lane(`SLTS_K281);
		rd(`SLTS_ADR_STATE, 8'h64, 8'h64);
		wr(`SLTS_ADR_STATE, 8'h00);
		rd(`SLTS_ADR_STATE, 8'h08, 8'h08);
		wr(`SLTS_ADR_STATE, 8'hff);
		rd(`SLTS_ADR_STATE, 8'h7c, 8'h64);
		$display("link bring-up test done");
		pulse();
		@(posedge clk);
		pulse();
		rd(`SLTS_ADR_STATE, 8'h18, 8'h10);
		wr(`SLTS_ADR_STATE, 8'h10);
		rd(`SLTS_ADR_STATE, 8'h10, 8'h00);
		@(posedge clk);
		pll_locked <= 1'b0;
		rd(`SLTS_ADR_STATE, 8'h04, 8'h00);
		@(posedge clk);
		hold <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`SLTS_ADR_STATE, 8'h20, 8'h00);
		$display("status flag test done");
		final_report;
	end
endmodule // slts_top_bench
`default_nettype wire
